// ==== src/crfc_control.sv ====
// Conversion result queue control: mode, capture, overwrite and read-back framing.
//
// What this block does
// [RULE_01] Control register at 0x3A, 24 bits, reset value 0x040200.
// [RULE_02] Bit 19 set puts one state word before the samples of a read.
// [RULE_03] With both bits set, state word once, each sample still tagged.
// [RULE_04] Bit 18 set, default, puts a tag before every sample word.
// [RULE_05] Mode 00 after reset disables the queue; results go to result register.
// [RULE_06] Mode 01 stores the first N results, N the fill threshold.
// [RULE_07] Mode 01 discards results until the queue is read out completely.
// [RULE_08] Reading a sample removes it from the queue.
// [RULE_09] Mode 01 sets overflow when a new result is discarded.
// [RULE_10] Modes 10 and 11 both select streaming of the newest results.
// [RULE_11] Streaming treats the queue as full only at its physical depth.
// [RULE_12] Streaming with a full queue and no read in that cycle drops the oldest sample and sets overflow.
// [RULE_13] Threshold value 0x00 means 256 samples, the whole queue.
// [RULE_14] Samples leave the queue oldest first, in write order.
`timescale 1ns/1ns
module crfc_control (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Converter result side
  input wire logic sample_valid_i,
  input wire logic [crfc_pkg::DATA_W-1:0] sample_data_i,
  input wire logic [crfc_pkg::TAG_W-1:0] sample_tag_i,
  // Register access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [crfc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [crfc_pkg::REG_W-1:0] reg_wdata_i,
  output logic [crfc_pkg::REG_W-1:0] reg_rdata_o,
  // Queue read command
  input wire logic rd_start_i,
  input wire logic rd_stop_i,
  input wire logic rd_word_req_i,
  output logic rd_word_valid_o,
  output logic rd_word_empty_o,
  output logic [crfc_pkg::DATA_W-1:0] rd_word_o,
  // Result register and state
  output logic [crfc_pkg::DATA_W-1:0] result_o,
  output logic [crfc_pkg::CNT_W-1:0] fill_count_o,
  output logic overflow_o
);
  localparam int ENTRY_W = crfc_pkg::DATA_W + crfc_pkg::TAG_W;

  typedef struct packed {
    logic [crfc_pkg::REG_W-1:0] ctrl;
    logic [crfc_pkg::PTR_W-1:0] wr_ptr;
    logic [crfc_pkg::PTR_W-1:0] rd_ptr;
    logic [crfc_pkg::CNT_W-1:0] count;
    logic locked;
    logic overflow;
    crfc_pkg::crfc_rd_t rd_state;
    logic word_valid;
    logic word_empty;
    logic [crfc_pkg::DATA_W-1:0] word;
    logic [crfc_pkg::REG_W-1:0] rdata;
    logic [crfc_pkg::DATA_W-1:0] result;
  } crfc_state_t;

  crfc_state_t s;
  crfc_state_t next_s;
  logic [ENTRY_W-1:0] head;
  logic [crfc_pkg::CNT_W-1:0] capacity;
  logic mark_reached;
  logic full;
  logic [crfc_pkg::MODE_W-1:0] mode;
  logic add_status;
  logic add_tag;
  logic push;
  logic pop;
  logic drop;
  logic discard;
  logic reg_hit;

  assign mode = s.ctrl[crfc_pkg::MODE_LSB +: crfc_pkg::MODE_W];
  assign add_status = s.ctrl[crfc_pkg::BIT_ADD_STATUS];
  assign add_tag = s.ctrl[crfc_pkg::BIT_ADD_TAG];
  assign reg_hit = (reg_addr_i == crfc_pkg::ADDR_QUEUE_CONTROL);

  crfc_store #(
    .WIDTH(ENTRY_W),
    .DEPTH(crfc_pkg::DEPTH),
    .PTR_W(crfc_pkg::PTR_W)
  ) u_store (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(push),
    .wr_addr_i(s.wr_ptr),
    .wr_data_i({sample_tag_i, sample_data_i}),
    .rd_addr_i(s.rd_ptr),
    .rd_data_o(head)
  );

  crfc_limit u_limit (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .mode_i(mode),
    .threshold_i(s.ctrl[crfc_pkg::THR_LSB +: crfc_pkg::THR_W]),
    .count_i(s.count),
    .capacity_o(capacity),
    .mark_reached_o(mark_reached),
    .full_o(full)
  );

  // A sample is read out only on a data word request with something stored.
  always_comb
  begin
    pop = (s.rd_state == crfc_pkg::RD_DATA) && rd_word_req_i && (s.count != '0); // RULE_08
    push = 1'b0;
    drop = 1'b0;
    discard = 1'b0;
    if (sample_valid_i && mode != crfc_pkg::MODE_OFF) // RULE_05
    begin
      if (mode == crfc_pkg::MODE_WATERMARK)
      begin
        discard = s.locked || full; // RULE_07
        push = !discard; // RULE_06
      end
      else
      begin
        // A pop in the same cycle frees a slot, so nothing is lost then.
        push = 1'b1; // RULE_10
        drop = full && !pop; // RULE_12
      end
    end
  end

  always_comb
  begin
    next_s = s;
    next_s.word_valid = 1'b0;
    next_s.word_empty = 1'b0;
    next_s.rdata = '0;
    if (sample_valid_i && mode == crfc_pkg::MODE_OFF)
    begin
      next_s.result = sample_data_i; // RULE_05
    end
    if (push)
    begin
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (pop || drop)
    begin
      next_s.rd_ptr = s.rd_ptr + 1'b1; // RULE_14
    end
    next_s.count = s.count + {{(crfc_pkg::CNT_W-1){1'b0}}, push && !drop}
      - {{(crfc_pkg::CNT_W-1){1'b0}}, pop};
    if (mode == crfc_pkg::MODE_WATERMARK && push && next_s.count >= capacity)
    begin
      next_s.locked = 1'b1; // RULE_07
    end
    if (s.locked && next_s.count == '0)
    begin
      next_s.locked = 1'b0; // RULE_07
    end

    case (s.rd_state)
      crfc_pkg::RD_IDLE:
      begin
        if (rd_start_i && mode != crfc_pkg::MODE_OFF)
        begin
          if (add_status)
          begin
            next_s.rd_state = crfc_pkg::RD_STATUS; // RULE_02
          end
          else if (add_tag)
          begin
            next_s.rd_state = crfc_pkg::RD_TAG;
          end
          else
          begin
            next_s.rd_state = crfc_pkg::RD_DATA;
          end
        end
      end
      crfc_pkg::RD_STATUS:
      begin
        if (rd_word_req_i)
        begin
          next_s.word = {{crfc_pkg::STAT_PAD_W{1'b0}}, s.overflow, mark_reached,
            s.count == '0, s.count};
          next_s.word_valid = 1'b1;
          // Reading the state word acknowledges overflow.
          next_s.overflow = 1'b0;
          next_s.rd_state = add_tag ? crfc_pkg::RD_TAG : crfc_pkg::RD_DATA; // RULE_03
        end
      end
      crfc_pkg::RD_TAG:
      begin
        if (rd_word_req_i)
        begin
          if (s.count == '0)
          begin
            next_s.word_empty = 1'b1;
          end
          else
          begin
            next_s.word = {{crfc_pkg::TAG_PAD_W{1'b0}},
              head[ENTRY_W-1 -: crfc_pkg::TAG_W]}; // RULE_04
            next_s.word_valid = 1'b1;
            next_s.rd_state = crfc_pkg::RD_DATA;
          end
        end
      end
      crfc_pkg::RD_DATA:
      begin
        if (rd_word_req_i)
        begin
          if (pop)
          begin
            next_s.word = head[crfc_pkg::DATA_W-1:0]; // RULE_14
            next_s.word_valid = 1'b1;
            next_s.rd_state = add_tag ? crfc_pkg::RD_TAG : crfc_pkg::RD_DATA; // RULE_03
          end
          else
          begin
            next_s.word_empty = 1'b1;
          end
        end
      end
      default:
      begin
        next_s.rd_state = crfc_pkg::RD_IDLE;
      end
    endcase
    if (rd_stop_i)
    begin
      next_s.rd_state = crfc_pkg::RD_IDLE;
    end

    // Loss is set after the acknowledge so an event in the same cycle is kept.
    if (discard)
    begin
      next_s.overflow = 1'b1; // RULE_09
    end
    if (drop)
    begin
      next_s.overflow = 1'b1; // RULE_12
    end

    if (reg_rd_i && reg_hit)
    begin
      next_s.rdata = s.ctrl;
    end
    if (reg_wr_i && reg_hit)
    begin
      next_s.ctrl = reg_wdata_i & crfc_pkg::QUEUE_CONTROL_WMASK; // RULE_01
      // A mode change starts from an empty queue, as old content has another meaning.
      if (reg_wdata_i[crfc_pkg::MODE_LSB +: crfc_pkg::MODE_W] != mode)
      begin
        next_s.wr_ptr = '0;
        next_s.rd_ptr = '0;
        next_s.count = '0;
        next_s.locked = 1'b0;
        next_s.rd_state = crfc_pkg::RD_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      s <= '0;
      s.ctrl <= crfc_pkg::QUEUE_CONTROL_RESET; // RULE_01
      s.rd_state <= crfc_pkg::RD_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign rd_word_valid_o = s.word_valid;
  assign rd_word_empty_o = s.word_empty;
  assign rd_word_o = s.word;
  assign result_o = s.result;
  assign fill_count_o = s.count;
  assign overflow_o = s.overflow;

  a_reset_value: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_01
    $past(reset_i) |-> (s.ctrl == crfc_pkg::QUEUE_CONTROL_RESET))
    else $error("Control register does not hold its reset value.");

  a_status_first: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_02
    (s.rd_state == crfc_pkg::RD_IDLE && rd_start_i && !rd_stop_i && mode != crfc_pkg::MODE_OFF
      && !(reg_wr_i && reg_hit)) |=> (s.rd_state == crfc_pkg::RD_STATUS) == add_status)
    else $error("State word not placed first as selected.");

  a_status_once: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_03
    (s.rd_state == crfc_pkg::RD_STATUS && rd_word_req_i && !rd_stop_i
      && !(reg_wr_i && reg_hit)) |=> (s.rd_state != crfc_pkg::RD_STATUS))
    else $error("State word repeated within one read.");

  a_tag_before: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_04
    (pop && add_tag && !rd_stop_i && !(reg_wr_i && reg_hit))
      |=> (s.rd_state == crfc_pkg::RD_TAG))
    else $error("Sample not followed by a tag slot.");

  a_off_no_store: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_05
    (mode == crfc_pkg::MODE_OFF) |-> !push ##1 (!$past(sample_valid_i) ||
      result_o == $past(sample_data_i)))
    else $error("Disabled queue stored a result or result register stale.");

  a_locked_discard: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_09
    (sample_valid_i && mode == crfc_pkg::MODE_WATERMARK && s.locked)
      |-> !push ##1 overflow_o)
    else $error("Discarded result did not raise overflow.");

  a_pop_removes: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_08
    (pop && !push && !(reg_wr_i && reg_hit)) |=> (s.count == $past(s.count) - 9'h001))
    else $error("Read sample not removed from the queue.");

  a_stream_drop: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_12
    (drop && !(reg_wr_i && reg_hit)) |=> overflow_o && s.count == crfc_pkg::CNT_DEPTH
      && s.rd_ptr == $past(s.rd_ptr) + 8'h01)
    else $error("Full streaming queue did not drop the oldest sample.");

  a_oldest_first: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_14
    pop |=> (rd_word_o == $past(head[crfc_pkg::DATA_W-1:0])) && rd_word_valid_o)
    else $error("Delivered word is not the oldest stored sample.");
endmodule

// ==== src/crfc_pkg.sv ====
// Shared constants and types of the conversion result queue control block.
package crfc_pkg;
  localparam int DATA_W = 24;
  localparam int TAG_W = 8;
  localparam int DEPTH = 256;
  localparam int PTR_W = 8;
  localparam int CNT_W = 9;
  localparam int ADDR_W = 6;
  localparam int REG_W = 24;
  localparam int THR_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_QUEUE_CONTROL = 6'h3A;
  localparam logic [REG_W-1:0] QUEUE_CONTROL_RESET = 24'h04_0200;
  // Bits [23:20] are reserved and read as zero.
  localparam logic [REG_W-1:0] QUEUE_CONTROL_WMASK = 24'h0F_FFFF;

  localparam int BIT_ADD_STATUS = 19;
  localparam int BIT_ADD_TAG = 18;
  localparam int MODE_LSB = 16;
  localparam int MODE_W = 2;
  localparam int THR_LSB = 0;

  localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
  localparam logic [MODE_W-1:0] MODE_WATERMARK = 2'h1;
  localparam logic [THR_W-1:0] THR_FULL_CODE = 8'h00;
  localparam logic [CNT_W-1:0] CNT_DEPTH = 9'h100;

  // Status word: pad, overflow, watermark reached, empty, fill count.
  localparam int STAT_PAD_W = REG_W - 3 - CNT_W;
  localparam int TAG_PAD_W = DATA_W - TAG_W;

  typedef enum logic [3:0] {
    RD_IDLE = 4'b0001,
    RD_STATUS = 4'b0010,
    RD_TAG = 4'b0100,
    RD_DATA = 4'b1000
  } crfc_rd_t;
endpackage

// ==== src/crfc_store.sv ====
// Sample storage array of the queue with one write and one read port.
`timescale 1ns/1ns
module crfc_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 256,
  parameter int PTR_W = 8
) (
  // Clock
  input wire logic ref_clk_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [PTR_W-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Read side
  input wire logic [PTR_W-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on the array: content is only read where the count says it is valid.
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rd_addr_i];
endmodule

// ==== src/crfc_limit.sv ====
// Capacity and full decision of the queue for the current mode.
`timescale 1ns/1ns
module crfc_limit (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Settings and state
  input wire logic [crfc_pkg::MODE_W-1:0] mode_i,
  input wire logic [crfc_pkg::THR_W-1:0] threshold_i,
  input wire logic [crfc_pkg::CNT_W-1:0] count_i,
  // Decisions
  output logic [crfc_pkg::CNT_W-1:0] capacity_o,
  output logic mark_reached_o,
  output logic full_o
);
  always_comb
  begin
    if (threshold_i == crfc_pkg::THR_FULL_CODE) // RULE_13
    begin
      capacity_o = crfc_pkg::CNT_DEPTH;
    end
    else
    begin
      capacity_o = {1'b0, threshold_i};
    end
    mark_reached_o = (count_i >= capacity_o);
    if (mode_i == crfc_pkg::MODE_WATERMARK)
    begin
      full_o = mark_reached_o;
    end
    else
    begin
      full_o = (count_i >= crfc_pkg::CNT_DEPTH); // RULE_11
    end
  end

  a_zero_code_cap: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_13
    (threshold_i == crfc_pkg::THR_FULL_CODE) |-> (capacity_o == crfc_pkg::CNT_DEPTH))
    else $error("Threshold code zero does not give full capacity.");

  a_stream_full_depth: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE_11
    (mode_i[1] && count_i < crfc_pkg::CNT_DEPTH) |-> !full_o)
    else $error("Streaming queue reported full below its depth.");
endmodule

// ==== tb/crfc_host.sv ====
// Host model that drives register accesses and queue read commands.
`timescale 1ns/1ns
module crfc_host (
  // Clock
  input wire logic ref_clk_i,
  // Register access
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [crfc_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [crfc_pkg::REG_W-1:0] reg_wdata_o,
  input wire logic [crfc_pkg::REG_W-1:0] reg_rdata_i,
  // Queue read command
  output logic rd_start_o,
  output logic rd_stop_o,
  output logic rd_word_req_o,
  input wire logic rd_word_valid_i,
  input wire logic rd_word_empty_i,
  input wire logic [crfc_pkg::DATA_W-1:0] rd_word_i
);
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 6'h00;
    reg_wdata_o = 24'h00_0000;
    rd_start_o = 1'b0;
    rd_stop_o = 1'b0;
    rd_word_req_o = 1'b0;
  end

  task automatic reg_write(input logic [5:0] addr, input logic [23:0] data);
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    // Idle data is scrambled so a late capture cannot pass by luck.
    reg_wdata_o <= ~data;
  endtask

  // Read data stands for one cycle only, so it is taken just after the edge.
  task automatic reg_read(input logic [5:0] addr, output logic [23:0] data);
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= addr;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    #1;
    data = reg_rdata_i;
  endtask

  task automatic command(input logic stop);
    @(posedge ref_clk_i);
    rd_start_o <= ~stop;
    rd_stop_o <= stop;
    @(posedge ref_clk_i);
    rd_start_o <= 1'b0;
    rd_stop_o <= 1'b0;
  endtask

  task automatic read_word(output logic [23:0] w, output logic v, output logic e);
    @(posedge ref_clk_i);
    rd_word_req_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_word_req_o <= 1'b0;
    #1;
    w = rd_word_i;
    v = rd_word_valid_i;
    e = rd_word_empty_i;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking testbench of the conversion result queue control block.
`timescale 1ns/1ns
module testbench;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sample_valid_i = 1'b0;
  logic [23:0] sample_data_i = 24'h00_0000;
  logic [7:0] sample_tag_i = 8'h00;
  logic reg_wr, reg_rd, rd_start, rd_stop, rd_req, w_valid, w_empty, overflow_o;
  logic [5:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, rd_word, result_o;
  logic [8:0] fill_count_o;
  int failures = 0;
  int compares = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  crfc_host u_host (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
    .rd_start_o(rd_start), .rd_stop_o(rd_stop), .rd_word_req_o(rd_req),
    .rd_word_valid_i(w_valid), .rd_word_empty_i(w_empty), .rd_word_i(rd_word));

  crfc_control u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .sample_valid_i(sample_valid_i), .sample_data_i(sample_data_i),
    .sample_tag_i(sample_tag_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .rd_start_i(rd_start), .rd_stop_i(rd_stop), .rd_word_req_i(rd_req),
    .rd_word_valid_o(w_valid), .rd_word_empty_o(w_empty), .rd_word_o(rd_word),
    .result_o(result_o), .fill_count_o(fill_count_o), .overflow_o(overflow_o));

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Holds the strobe up across a burst, one result per cycle.
  task automatic push(input int n, input logic [23:0] base);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk_i);
      sample_valid_i <= 1'b1;
      sample_data_i <= base + 24'(i);
      sample_tag_i <= 8'(i);
    end
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b0;
    #1;
  endtask

  task automatic get(input string name, input logic [23:0] exp);
    logic [23:0] w;
    logic v;
    logic e;
    u_host.read_word(w, v, e);
    chk({name, " valid"}, {23'h0, v}, 24'h00_0001);
    chk(name, w, exp);
  endtask

  initial
  begin
    #1_000_000;
    failures++;
    give_verdict();
  end

  initial
  begin
    logic [23:0] r;
    logic v;
    logic e;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    u_host.reg_read(6'h3A, r);
    chk("control reset", r, 24'h04_0200);
    u_host.reg_read(6'h3B, r);
    chk("unmapped read", r, 24'h00_0000);
    push(1, 24'h12_3456);
    chk("result register", result_o, 24'h12_3456);
    chk("count disabled", {15'h0, fill_count_o}, 24'h00_0000);
    u_host.command(1'b0);
    u_host.read_word(r, v, e);
    chk("no answer disabled", {22'h0, v, e}, 24'h00_0000);
    $display("test reset and disabled mode done");

    // Status and tags on, capture mode, threshold of two; reserved bits are written high.
    u_host.reg_write(6'h3A, 24'hFD_0002);
    u_host.reg_read(6'h3A, r);
    chk("control readback", r, 24'h0D_0002);
    push(3, 24'hA0_0000);
    chk("capture count", {15'h0, fill_count_o}, 24'h00_0002);
    chk("capture overflow", {23'h0, overflow_o}, 24'h00_0001);
    u_host.command(1'b0);
    get("status word", 24'h00_0C02);
    get("tag 0", 24'h00_0000);
    get("data 0", 24'hA0_0000);
    chk("overflow cleared", {23'h0, overflow_o}, 24'h00_0000);
    push(1, 24'hC0_0000);
    chk("locked count", {15'h0, fill_count_o}, 24'h00_0001);
    chk("locked overflow", {23'h0, overflow_o}, 24'h00_0001);
    get("tag 1", 24'h00_0001);
    get("data 1", 24'hA0_0001);
    u_host.read_word(r, v, e);
    chk("drained", {22'h0, v, e}, 24'h00_0001);
    push(1, 24'hB0_0000);
    chk("resumed count", {15'h0, fill_count_o}, 24'h00_0001);
    u_host.command(1'b1);
    $display("test capture mode done");

    for (int m = 2; m < 4; m++)
    begin
      u_host.reg_write(6'h3A, {6'h02, 2'(m), 8'h00, (m == 2) ? 8'h02 : 8'h00});
      push(257, 24'h50_0000);
      chk("stream count", {15'h0, fill_count_o}, 24'h00_0100);
      u_host.command(1'b0);
      get("stream status", 24'h00_0D00);
      get("oldest kept", 24'h50_0001);
      chk("after pop", {15'h0, fill_count_o}, 24'h00_00FF);
      // Below the depth the mark bit tells a zero threshold code from a small one.
      u_host.command(1'b1);
      u_host.command(1'b0);
      get("mark after pop", (m == 2) ? 24'h00_04FF : 24'h00_00FF);
      u_host.command(1'b1);
      $display("test streaming mode %0d done", m);
    end

    // Same mode with tags only: the queue is kept and the stream opens on a tag.
    u_host.reg_write(6'h3A, 24'h07_0000);
    u_host.command(1'b0);
    get("tag only", 24'h00_0002);
    get("data after tag", 24'h50_0002);
    u_host.command(1'b1);
    $display("test tag only done");
    give_verdict();
  end
endmodule
